/* hw/bcr_pkg.sv */
// Constants, types and helpers for the bridge capability register bank.
// Assumes one core clock; used by the register bank and its pad selector.
`default_nettype none

package bcr_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GLB_EN    = 8'h48;
  localparam logic [7:0] ADDR_COMP_RISE = 8'h50;
  localparam logic [7:0] ADDR_COMP_FALL = 8'h54;
  localparam logic [7:0] ADDR_HP_IDX    = 8'h90;
  localparam logic [7:0] ADDR_HP_DATA   = 8'h94;
  localparam logic [7:0] ADDR_PM_CAP    = 8'h98;
  localparam logic [7:0] ADDR_PM_SC     = 8'h9c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int COMP_MUSTLOW_BIT = 31;
  localparam int COMP_CALC_LSB    = 16;
  localparam int COMP_SEL_LSB     = 5;
  localparam int COMP_SW_LSB      = 0;
  localparam int GLB_HPEN_A_BIT   = 0;
  localparam int HP_IRQ_PEND_BIT  = 31;
  localparam int HP_SERR_PEND_BIT = 30;
  localparam int HP_SEL_LSB       = 16;
  localparam int PM_BPCC_BIT      = 23;
  localparam int PM_STS_BIT       = 15;
  localparam int PM_EN_BIT        = 8;
  localparam int PM_STATE_LSB     = 0;

  // ----------------------------------------------------------------
  // Fixed values and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] HP_CAP_LOW   = 16'h980c;
  localparam logic [31:0] PM_CAP_VALUE = 32'h480a_c001;
  localparam logic        PM_BPCC_VAL  = 1'b0;
  localparam logic [1:0]  SEL_CALC     = 2'b00;
  localparam logic [1:0]  SEL_SW       = 2'b01;
  localparam logic [1:0]  SEL_ADD      = 2'b10;
  localparam logic [1:0]  SEL_SUB      = 2'b11;
  localparam logic [1:0]  PS_D0        = 2'b00;
  localparam logic [1:0]  PS_D3HOT     = 2'b11;
  localparam logic [3:0]  COMP_MAX     = 4'hf;
  localparam logic [3:0]  COMP_MIN     = 4'h0;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WR, ST_RD, ST_HWAIT, ST_BRESP, ST_RRESP
  } bcr_st_t;

  // Compensation choice: pass, saturating sum or clamped difference
  function automatic logic [3:0] comp_pick(input logic [1:0] sel,
                                           input logic [3:0] calc,
                                           input logic [3:0] sw);
    logic [4:0] sum;
    sum = {1'b0, calc} + {1'b0, sw};
    case (sel)
      SEL_CALC: comp_pick = calc; // RULE1
      SEL_SW:   comp_pick = sw; // RULE1
      SEL_ADD:  comp_pick = sum[4] ? COMP_MAX : sum[3:0]; // RULE2
      default:  comp_pick = (calc < sw) ? COMP_MIN : 4'(calc - sw); // RULE3
    endcase
  endfunction

  // Byte-lane merge of a write onto the current value
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    lane_merge = (old & ~m) | (wd & m);
  endfunction

endpackage

`default_nettype wire

/* hw/bcr_comp_sel.sv */
// Pad drive-strength selector for one edge of the bridge A outputs.
// Assumes select and software value come from registers of the bank.
`default_nettype none

module bcr_comp_sel
  import bcr_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic [1:0] sel_i,
  input  wire logic [3:0] sw_i,
  input  wire logic [3:0] calc_i,
  output var  logic [3:0] drive_o
);

  // ----------------------------------------------------------------
  // Registered result
  // ----------------------------------------------------------------
  logic [3:0] drive_q;
  logic [3:0] drive_d;

  // Result recomputed every cycle, seen one cycle after a change
  always_comb begin
    drive_d = comp_pick(sel_i, calc_i, sw_i); // RULE22
  end

  // Mid-scale would be kinder, but zero keeps reset deterministic
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drive_q <= 4'h0;
    end else begin
      drive_q <= drive_d;
    end
  end

  assign drive_o = drive_q;

endmodule

`default_nettype wire

/* hw/bcr_regs.sv */
// Bridge A capability and configuration register bank on AXI4-Lite.
// Assumes the hot-plug controller answers a window access with an ack
// pulse, and that the calculated compensation inputs are synchronous.
//
// Functional notes
// (RULE1) Select 6:5; 00 passes calculated value, 01 passes software value
// (RULE2) Select 10 adds calculated and software value, saturating at Fh
// (RULE3) Select 11 subtracts software from calculated, clamping at 0h
// (RULE4) Software value is RW at bits 3:0; bit 4 reserved
// (RULE5) Hot-plug and power registers read as reserved when enable low
// (RULE6) Index register bit 31 is OR of controller register 18
// (RULE7) Index register bit 30 is OR of controller register 1C
// (RULE8) Index bits 23:16 select window dword, byte offset index times 4
// (RULE9) Every data window access is forwarded to the selected register; none is forwarded while enable is low
// (RULE10) Power capability next pointer reads C0h for bridge A
// (RULE11) Event support only D0 and D3 hot; D2, D1 unsupported
// (RULE12) No aux current, no special init, version 1.1
// (RULE13) Bit 19 says the bus clock is needed for wake events
// (RULE14) Status bit 23 reads policies disabled
// (RULE15) Wake status set by hardware event, cleared by writing 1
// (RULE16) Wake output only while enable bit 8 and status are set
// (RULE17) Power state bits 1:0 report D0 or D3 hot
// (RULE18) Writes of 01 or 10 to power state complete but are dropped
// (RULE19) Calculated value read-only at bits 19:16 from compensation input
// (RULE20) Register 0x50 drives rising edges, 0x54 falling edges
// (RULE21) Reserved bits read zero and ignore writes
// (RULE22) Selected result registered and driven continuously to pads
`default_nettype none

module bcr_regs
  import bcr_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output var  logic        s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output var  logic        s_axi_wready_o,
  output var  logic [1:0]  s_axi_bresp_o,
  output var  logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output var  logic        s_axi_arready_o,
  output var  logic [31:0] s_axi_rdata_o,
  output var  logic [1:0]  s_axi_rresp_o,
  output var  logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic [3:0]  comp_calc_rise_i,
  input  wire logic [3:0]  comp_calc_fall_i,
  output var  logic [3:0]  pad_drive_rise_o,
  output var  logic [3:0]  pad_drive_fall_o,
  input  wire logic [31:0] hpc_irq_bits_i,
  input  wire logic [31:0] hpc_serr_bits_i,
  input  wire logic        hpc_wake_event_i,
  output var  logic        hpc_req_o,
  output var  logic        hpc_we_o,
  output var  logic [9:0]  hpc_addr_o,
  output var  logic [31:0] hpc_wdata_o,
  output var  logic [3:0]  hpc_wstrb_o,
  input  wire logic [31:0] hpc_rdata_i,
  input  wire logic        hpc_ack_i,
  output var  logic        wake_event_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bcr_st_t     st;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        is_wr;
    logic        hp_en_a;
    logic        mustlow_r;
    logic [1:0]  sel_r;
    logic [3:0]  sw_r;
    logic        mustlow_f;
    logic [1:0]  sel_f;
    logic [3:0]  sw_f;
    logic [7:0]  hp_sel;
    logic        wk_sts;
    logic        wk_en;
    logic [1:0]  pstate;
    logic        wake;
    logic        hpc_req;
    logic        hpc_we;
    logic [9:0]  hpc_addr;
    logic [31:0] hpc_wdata;
    logic [3:0]  hpc_wstrb;
  } bcr_regs_state_t;

  bcr_regs_state_t s_q;
  bcr_regs_state_t s_d;
  logic [31:0]     rd_val;
  logic [31:0]     wr_val;
  logic            mapped;
  logic            gated;
  logic            is_win;

  // ----------------------------------------------------------------
  // Read mux of the latched address
  // ----------------------------------------------------------------
  // Gated registers collapse to zero so a disabled bridge looks empty
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    gated  = 1'b0;
    case (s_q.addr)
      ADDR_GLB_EN: begin
        rd_val[GLB_HPEN_A_BIT] = s_q.hp_en_a;
      end
      ADDR_COMP_RISE: begin // RULE20
        rd_val[COMP_MUSTLOW_BIT]            = s_q.mustlow_r;
        rd_val[COMP_CALC_LSB +: 4]          = comp_calc_rise_i; // RULE19
        rd_val[COMP_SEL_LSB +: 2]           = s_q.sel_r;
        rd_val[COMP_SW_LSB +: 4]            = s_q.sw_r; // RULE4
      end
      ADDR_COMP_FALL: begin // RULE20
        rd_val[COMP_MUSTLOW_BIT]            = s_q.mustlow_f;
        rd_val[COMP_CALC_LSB +: 4]          = comp_calc_fall_i; // RULE19
        rd_val[COMP_SEL_LSB +: 2]           = s_q.sel_f;
        rd_val[COMP_SW_LSB +: 4]            = s_q.sw_f; // RULE4
      end
      ADDR_HP_IDX: begin
        gated                     = 1'b1;
        rd_val[HP_IRQ_PEND_BIT]   = |hpc_irq_bits_i; // RULE6
        rd_val[HP_SERR_PEND_BIT]  = |hpc_serr_bits_i; // RULE7
        rd_val[HP_SEL_LSB +: 8]   = s_q.hp_sel; // RULE8
        rd_val[15:0]              = HP_CAP_LOW;
      end
      ADDR_HP_DATA: begin
        gated = 1'b1;
      end
      ADDR_PM_CAP: begin
        gated  = 1'b1;
        rd_val = PM_CAP_VALUE; // RULE10 RULE11 RULE12 RULE13
      end
      ADDR_PM_SC: begin
        gated                     = 1'b1;
        rd_val[PM_BPCC_BIT]       = PM_BPCC_VAL; // RULE14
        rd_val[PM_STS_BIT]        = s_q.wk_sts;
        rd_val[PM_EN_BIT]         = s_q.wk_en;
        rd_val[PM_STATE_LSB +: 2] = s_q.pstate; // RULE17
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    if (gated && !s_q.hp_en_a) begin
      rd_val = 32'h0000_0000; // RULE5
    end
    is_win = (s_q.addr == ADDR_HP_DATA) && s_q.hp_en_a;
    wr_val = lane_merge(rd_val, s_q.wdata, s_q.wstrb);
  end

  // ----------------------------------------------------------------
  // Bus sequencing and register updates
  // ----------------------------------------------------------------
  // One access at a time; writes win a tie with reads
  always_comb begin
    s_d         = s_q;
    s_d.awready = 1'b0;
    s_d.wready  = 1'b0;
    s_d.arready = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        if (s_axi_awvalid_i && s_axi_wvalid_i) begin
          s_d.awready = 1'b1;
          s_d.wready  = 1'b1;
          s_d.addr    = s_axi_awaddr_i;
          s_d.wdata   = s_axi_wdata_i;
          s_d.wstrb   = s_axi_wstrb_i;
          s_d.st      = ST_WR;
        end else if (s_axi_arvalid_i) begin
          s_d.arready = 1'b1;
          s_d.addr    = s_axi_araddr_i;
          s_d.st      = ST_RD;
        end
      end
      ST_WR: begin
        s_d.bresp = mapped ? RESP_OKAY : RESP_SLVERR;
        if (is_win) begin // RULE9
          s_d.hpc_req   = 1'b1;
          s_d.hpc_we    = 1'b1;
          s_d.hpc_addr  = {s_q.hp_sel, 2'b00}; // RULE8
          s_d.hpc_wdata = s_q.wdata;
          s_d.hpc_wstrb = s_q.wstrb;
          s_d.is_wr     = 1'b1;
          s_d.st        = ST_HWAIT;
        end else begin
          s_d.bvalid = 1'b1;
          s_d.st     = ST_BRESP;
          // Reserved bits are simply never stored
          case (s_q.addr) // RULE21
            ADDR_GLB_EN: begin
              s_d.hp_en_a = wr_val[GLB_HPEN_A_BIT];
            end
            ADDR_COMP_RISE: begin
              s_d.mustlow_r = wr_val[COMP_MUSTLOW_BIT];
              s_d.sel_r     = wr_val[COMP_SEL_LSB +: 2];
              s_d.sw_r      = wr_val[COMP_SW_LSB +: 4]; // RULE4
            end
            ADDR_COMP_FALL: begin
              s_d.mustlow_f = wr_val[COMP_MUSTLOW_BIT];
              s_d.sel_f     = wr_val[COMP_SEL_LSB +: 2];
              s_d.sw_f      = wr_val[COMP_SW_LSB +: 4];
            end
            ADDR_HP_IDX: begin
              if (s_q.hp_en_a) begin // RULE5
                s_d.hp_sel = wr_val[HP_SEL_LSB +: 8];
              end
            end
            ADDR_PM_SC: begin
              if (s_q.hp_en_a) begin
                if (s_q.wstrb[1] && s_q.wdata[PM_STS_BIT]) begin
                  s_d.wk_sts = 1'b0; // RULE15
                end
                s_d.wk_en = wr_val[PM_EN_BIT];
                if (wr_val[PM_STATE_LSB +: 2] == PS_D0 ||
                    wr_val[PM_STATE_LSB +: 2] == PS_D3HOT) begin
                  s_d.pstate = wr_val[PM_STATE_LSB +: 2]; // RULE18
                end
              end
            end
            default: begin
              s_d.st = ST_BRESP;
            end
          endcase
        end
      end
      ST_RD: begin
        s_d.rresp = mapped ? RESP_OKAY : RESP_SLVERR;
        if (is_win) begin // RULE9
          s_d.hpc_req  = 1'b1;
          s_d.hpc_we   = 1'b0;
          s_d.hpc_addr = {s_q.hp_sel, 2'b00};
          s_d.is_wr    = 1'b0;
          s_d.st       = ST_HWAIT;
        end else begin
          s_d.rdata  = rd_val;
          s_d.rvalid = 1'b1;
          s_d.st     = ST_RRESP;
        end
      end
      ST_HWAIT: begin
        // Bus stalls until the controller answers; no timeout here
        if (hpc_ack_i) begin
          s_d.hpc_req = 1'b0;
          s_d.hpc_we  = 1'b0;
          if (s_q.is_wr) begin
            s_d.bvalid = 1'b1;
            s_d.st     = ST_BRESP;
          end else begin
            s_d.rdata  = hpc_rdata_i;
            s_d.rvalid = 1'b1;
            s_d.st     = ST_RRESP;
          end
        end
      end
      ST_BRESP: begin
        if (s_axi_bready_i) begin
          s_d.bvalid = 1'b0;
          s_d.st     = ST_IDLE;
        end
      end
      ST_RRESP: begin
        if (s_axi_rready_i) begin
          s_d.rvalid = 1'b0;
          s_d.st     = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    // Event after the clear so a coincident event is kept
    if (hpc_wake_event_i) begin
      s_d.wk_sts = 1'b1; // RULE15
    end
    s_d.wake = s_d.wk_en && s_d.wk_sts; // RULE16
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Pad selectors and outputs
  // ----------------------------------------------------------------
  bcr_comp_sel u_rise (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .sel_i     (s_q.sel_r),
    .sw_i      (s_q.sw_r),
    .calc_i    (comp_calc_rise_i),
    .drive_o   (pad_drive_rise_o)
  );

  bcr_comp_sel u_fall (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .sel_i     (s_q.sel_f),
    .sw_i      (s_q.sw_f),
    .calc_i    (comp_calc_fall_i),
    .drive_o   (pad_drive_fall_o)
  );

  assign s_axi_awready_o = s_q.awready;
  assign s_axi_wready_o  = s_q.wready;
  assign s_axi_bvalid_o  = s_q.bvalid;
  assign s_axi_bresp_o   = s_q.bresp;
  assign s_axi_arready_o = s_q.arready;
  assign s_axi_rvalid_o  = s_q.rvalid;
  assign s_axi_rresp_o   = s_q.rresp;
  assign s_axi_rdata_o   = s_q.rdata;
  assign hpc_req_o       = s_q.hpc_req;
  assign hpc_we_o        = s_q.hpc_we;
  assign hpc_addr_o      = s_q.hpc_addr;
  assign hpc_wdata_o     = s_q.hpc_wdata;
  assign hpc_wstrb_o     = s_q.hpc_wstrb;
  assign wake_event_o    = s_q.wake;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_sel_calc;
    (s_q.sel_r == SEL_CALC) |=> pad_drive_rise_o == $past(comp_calc_rise_i);
  endproperty
  a_sel_calc: assert property (p_sel_calc) // RULE1
    else $error("rise pad not the calculated value");

  property p_sel_sum_sat;
    (s_q.sel_r == SEL_ADD && ({1'b0, comp_calc_rise_i} +
      {1'b0, s_q.sw_r}) > 5'h0f) |=> pad_drive_rise_o == COMP_MAX;
  endproperty
  a_sel_sum_sat: assert property (p_sel_sum_sat) // RULE2
    else $error("sum did not saturate");

  property p_sel_diff_clamp;
    (s_q.sel_f == SEL_SUB && comp_calc_fall_i < s_q.sw_f)
      |=> pad_drive_fall_o == COMP_MIN;
  endproperty
  a_sel_diff_clamp: assert property (p_sel_diff_clamp) // RULE3
    else $error("difference did not clamp");

  property p_gated_zero;
    $rose(s_q.rvalid) && gated && !s_q.hp_en_a |-> s_axi_rdata_o == '0;
  endproperty
  a_gated_zero: assert property (p_gated_zero) // RULE5
    else $error("disabled register read non-zero");

  property p_irq_pend;
    $rose(s_q.rvalid) && s_q.addr == ADDR_HP_IDX && s_q.hp_en_a
      |-> s_axi_rdata_o[HP_IRQ_PEND_BIT] == $past(|hpc_irq_bits_i);
  endproperty
  a_irq_pend: assert property (p_irq_pend) // RULE6
    else $error("pending summary wrong");

  property p_win_fwd;
    s_q.st == ST_RD && is_win |=> hpc_req_o && !hpc_we_o;
  endproperty
  a_win_fwd: assert property (p_win_fwd) // RULE9
    else $error("window read not forwarded");

  property p_next_ptr;
    $rose(s_q.rvalid) && s_q.addr == ADDR_PM_CAP && s_q.hp_en_a
      |-> s_axi_rdata_o[15:8] == 8'hc0;
  endproperty
  a_next_ptr: assert property (p_next_ptr) // RULE10
    else $error("next pointer wrong");

  property p_wake_set;
    hpc_wake_event_i |=> s_q.wk_sts;
  endproperty
  a_wake_set: assert property (p_wake_set) // RULE15
    else $error("wake status not set");

  property p_wake_gate;
    wake_event_o |-> s_q.wk_en && s_q.wk_sts;
  endproperty
  a_wake_gate: assert property (p_wake_gate) // RULE16
    else $error("wake output without enable and status");

  property p_pstate_legal;
    s_q.pstate == PS_D0 || s_q.pstate == PS_D3HOT;
  endproperty
  a_pstate_legal: assert property (p_pstate_legal) // RULE18
    else $error("unsupported power state stored");

  c_win_write: cover property (s_q.st == ST_HWAIT && s_q.is_wr && hpc_ack_i);
  c_wake_out:  cover property ($rose(wake_event_o));
  c_sat_sum:   cover property (s_q.sel_r == SEL_ADD && pad_drive_rise_o == 4'hf);

endmodule

`default_nettype wire

/* sim/tb_bcr_regs.sv */
// Self-checking bench for the bridge capability register bank.
// Assumes the bank alone; the bench stands in for the hot-plug controller.
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end

module tb_bcr_regs
  import bcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic [7:0]  awaddr    = '0;
  logic [7:0]  araddr    = '0;
  logic [31:0] wdata     = '0;
  logic [3:0]  wstrb     = '0;
  logic        awvalid   = 1'b0;
  logic        wvalid    = 1'b0;
  logic        bready    = 1'b0;
  logic        arvalid   = 1'b0;
  logic        rready    = 1'b0;
  logic [3:0]  calc_r    = 4'h7;
  logic [3:0]  calc_f    = 4'h0;
  logic [31:0] irq_b     = '0;
  logic [31:0] serr_b    = '0;
  logic [31:0] hrdata    = '0;
  logic [31:0] m_wdata   = '0;
  logic [9:0]  m_addr    = '0;
  logic        m_we      = 1'b0;
  logic        wake_ev   = 1'b0;
  logic        ack       = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, wake, hreq, hwe;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, hwdata;
  logic [3:0]  pad_r, pad_f, hwstrb;
  logic [9:0]  haddr;
  logic [31:0] pm [10];
  logic [13:0] tab [6];
  int          fails = 0;
  int          checks = 0;
  int          acks = 0;
  int          n;

  always #20 sys_clk_i = ~sys_clk_i;

  // Controller stand-in: one ack per request; data scrambled when idle
  always @(posedge sys_clk_i) begin
    ack <= hreq & ~ack;
    if (hreq & ~ack) begin
      hrdata  <= {16'h5a5a, 6'h0, haddr};
      m_we    <= hwe;
      m_addr  <= haddr;
      m_wdata <= hwdata;
      acks    <= acks + 1;
    end else begin
      hrdata <= ~hrdata;
    end
  end

  bcr_regs u_bcr_regs (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .comp_calc_rise_i(calc_r),
    .comp_calc_fall_i(calc_f), .pad_drive_rise_o(pad_r),
    .pad_drive_fall_o(pad_f), .hpc_irq_bits_i(irq_b),
    .hpc_serr_bits_i(serr_b), .hpc_wake_event_i(wake_ev),
    .hpc_req_o(hreq), .hpc_we_o(hwe), .hpc_addr_o(haddr),
    .hpc_wdata_o(hwdata), .hpc_wstrb_o(hwstrb), .hpc_rdata_i(hrdata),
    .hpc_ack_i(ack), .wake_event_o(wake)
  );

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk_i);
  endtask

  // Address and data released each on its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge sys_clk_i);
      if (awready === 1'b1) aw = 1'b0;
      if (wready === 1'b1) w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
    end
    bready <= 1'b1;
    do @(posedge sys_clk_i); while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
    @(posedge sys_clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge sys_clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge sys_clk_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
    `CHK($sformatf("rdata %h", a), e, rdata)
    `CHK("rresp", er, rresp)
    @(posedge sys_clk_i);
  endtask

  task automatic pulse();
    wake_ev <= 1'b1;
    @(posedge sys_clk_i);
    wake_ev <= 1'b0;
    tick(2);
  endtask

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run is under three hundred cycles; this leaves ample margin
  initial begin
    tick(20000);
    fails++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    tab = '{14'h0399, 14'h1393, 14'h299f, 14'h2347, 14'h3940, 14'h3396};
    pm = '{32'hffff_ffff, 32'h103, 32'h101, 32'h103, 32'h102, 32'h103,
           32'h100, 32'h100, 32'h103, 32'h103};
    tick(16);
    nrst_i <= 1'b1;
    tick(3);
    `CHK("pad rise", 4'h7, pad_r)
    rd(ADDR_HP_IDX, 32'h0, RESP_OKAY);
    rd(ADDR_PM_SC, 32'h0, RESP_OKAY);
    rd(8'h00, 32'h0, RESP_SLVERR);
    wr(8'h04, 32'h1, RESP_SLVERR);
    $display("test reset done");
    // Reserved and read-only bits written high, bridge B bits left alone
    foreach (tab[i]) begin
      calc_r <= tab[i][7:4];
      wr(ADDR_COMP_RISE, {12'h7ff, 4'hf, 9'h0, tab[i][13:12], 1'b1,
         tab[i][11:8]}, RESP_OKAY);
      tick(2);
      `CHK("pad rise", tab[i][3:0], pad_r)
      rd(ADDR_COMP_RISE, {12'h0, tab[i][7:4], 9'h0, tab[i][13:12], 1'b0,
         tab[i][11:8]}, RESP_OKAY);
    end
    calc_r <= 4'hc;
    tick(3);
    `CHK("pad follow", 4'h9, pad_r)
    calc_f <= 4'h5;
    wr(ADDR_COMP_FALL, 32'h0000_0045, RESP_OKAY);
    tick(2);
    `CHK("pad fall", 4'ha, pad_f)
    `CHK("pad rise kept", 4'h9, pad_r)
    wr(ADDR_COMP_FALL, 32'h0000_0068, RESP_OKAY);
    tick(2);
    `CHK("pad fall clamp", 4'h0, pad_f)
    $display("test compensation done");
    wr(ADDR_GLB_EN, 32'h1, RESP_OKAY);
    rd(ADDR_HP_IDX, 32'h0000_980c, RESP_OKAY);
    irq_b <= 32'h0001_0000;
    rd(ADDR_HP_IDX, 32'h8000_980c, RESP_OKAY);
    irq_b <= 32'h0;
    serr_b <= 32'h8000_0000;
    rd(ADDR_HP_IDX, 32'h4000_980c, RESP_OKAY);
    wr(ADDR_HP_IDX, 32'hff05_ffff, RESP_OKAY);
    rd(ADDR_HP_IDX, 32'h4005_980c, RESP_OKAY);
    wr(ADDR_HP_DATA, 32'hdead_beef, RESP_OKAY);
    `CHK("window addr", 10'h014, m_addr)
    `CHK("window wdata", 32'hdead_beef, m_wdata)
    `CHK("window we", 1'b1, m_we)
    `CHK("window wstrb", 4'hf, hwstrb)
    rd(ADDR_HP_DATA, 32'h5a5a_0014, RESP_OKAY);
    wr(ADDR_HP_IDX, 32'h00ff_0000, RESP_OKAY);
    rd(ADDR_HP_DATA, 32'h5a5a_03fc, RESP_OKAY);
    `CHK("window we", 1'b0, m_we)
    $display("test window done");
    wr(ADDR_PM_CAP, 32'h0, RESP_OKAY);
    rd(ADDR_PM_CAP, 32'h480a_c001, RESP_OKAY);
    for (int i = 0; i < 10; i += 2) begin
      wr(ADDR_PM_SC, pm[i], RESP_OKAY);
      rd(ADDR_PM_SC, pm[i+1], RESP_OKAY);
    end
    $display("test power state done");
    wr(ADDR_PM_SC, 32'h100, RESP_OKAY);
    pulse();
    `CHK("wake out", 1'b1, wake)
    wr(ADDR_PM_SC, 32'h100, RESP_OKAY);
    rd(ADDR_PM_SC, 32'h8100, RESP_OKAY);
    wr(ADDR_PM_SC, 32'h8000, RESP_OKAY);
    rd(ADDR_PM_SC, 32'h0, RESP_OKAY);
    `CHK("wake out", 1'b0, wake)
    pulse();
    `CHK("wake masked", 1'b0, wake)
    rd(ADDR_PM_SC, 32'h8000, RESP_OKAY);
    wr(ADDR_PM_SC, 32'h100, RESP_OKAY);
    tick(1);
    `CHK("wake late", 1'b1, wake)
    $display("test wake done");
    wr(ADDR_GLB_EN, 32'h0, RESP_OKAY);
    n = acks;
    wr(ADDR_HP_DATA, 32'h1, RESP_OKAY);
    rd(ADDR_HP_DATA, 32'h0, RESP_OKAY);
    rd(ADDR_PM_CAP, 32'h0, RESP_OKAY);
    `CHK("gated requests", n, acks)
    $display("test gating done");
    finish_test();
  end

endmodule

`default_nettype wire
